// file: verilog/ccr_consts.vh
// Constants for the codec control block: offsets, fields, resets, timing
// Assumes inclusion by bare name from the design files only
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH
// Register byte offsets
`define CCR_OFF_INDEX    8'h00
`define CCR_OFF_STATUS   8'h04
`define CCR_OFF_CONFIG   8'h08
`define CCR_OFF_RATEFMT  8'h0C
`define CCR_OFF_CAPFMT   8'h10
`define CCR_OFF_ALTRATE  8'h14
`define CCR_OFF_INDCTRL  8'h18
`define CCR_OFF_CAPRATE  8'h1C
`define CCR_OFF_PLAYRATE 8'h20
`define CCR_OFF_AFCTRL   8'h24
`define CCR_OFF_AFSTAT   8'h28
`define CCR_OFF_PBASE    8'h2C
`define CCR_OFF_CBASE    8'h30
`define CCR_OFF_PCOUNT   8'h34
`define CCR_OFF_CCOUNT   8'h38
// Field positions
`define CCR_IDX_MCE      0
`define CCR_CFG_CAL_LO   0
`define CCR_CFG_PLAY_PROG_IO     2
`define CCR_CFG_CAP_PROG_IO     3
`define CCR_CFG_PEN      4
`define CCR_CFG_CEN      5
`define CCR_CFG_IEN      6
`define CCR_CFG_EXT      7
`define CCR_CFG_PDN      8
`define CCR_CFG_OSM_LO   9
`define CCR_CFG_OSM_HI   10
`define CCR_ALT_SRE      0
`define CCR_IND_INDEPENDENT_RATE_ENABLE     0
`define CCR_AFC_PLAY_FORMAT_CHANGE     0
`define CCR_AFC_CAP_FORMAT_CHANGE     1
`define CCR_AFS_ACI      0
`define CCR_AFS_PI       4
`define CCR_AFS_CI       5
`define CCR_ST_INT       0
`define CCR_FMT_STEREO   4
`define CCR_FMT_WIDE     5
// Reset values and answers
`define CCR_RST_BYTE     8'h00
`define CCR_RST_BASE     16'h0000
`define CCR_BUSY_VALUE   32'h0000_0080
`define CCR_RESP_OKAY    2'b00
`define CCR_RESP_SLVERR  2'b10
// Timing
`define CCR_CLK_HZ       125000000
`define CCR_SAMPLE_HZ    44100
`define CCR_SAMPLE_DIV   (`CCR_CLK_HZ / `CCR_SAMPLE_HZ)
`define CCR_CAL_DAC_PER  9'h078
`define CCR_CAL_CONV_PER 9'h141
`define CCR_CAL_FULL_PER 9'h1C2
`define CCR_FULL_ADC_AT  9'h12C
`define CCR_FULL_DAC_AT  9'h096
`define CCR_CONV_DAC_AT  9'h0A0
`define CCR_RESYNC_PER   2'h2
`endif

// file: verilog/ccr_codec_ctrl.v
// Codec control: calibration, rate select, formats, DMA sample counters
// Assumes an AXI4-Lite master on aclk and same-clock DMA byte/sample strobes
//
// What this block does
// - DAC calibration mutes, clears filters, 120 periods
// - Full calibration: mute, mixer, ADC, DAC; 450 periods
// - Full calibration at power-up and power-down exit
// - During resync ignore writes, reads return busy
// - Alternate rate overrides low rate bits, no mode-change
// - Independent rate uses separate capture/playback registers
// - Basic mode shares format, needs mode-change
// - Format-change enable flushes FIFO, unlocks format bits
// - Frequency change still needs global mode-change
// - Left sample always precedes right sample
// - 16-bit samples signed, low byte first
// - 8-bit samples unsigned offset binary
// - Upper base write loads current count
// - DMA runs when enabled, not programmed I/O, not calibrating; basic-mode capture only while playback DMA is off
// - Count decrements per sample, rollunder flags, reloads
// - Basic mode shares playback counter for both
// - Playback rollunder sets flag; write clears
// - Extended mode separate capture base and flag
// - Calibration starts on mode-change fall; busy bit
// - Code 00 none; code 01 converters, 321
// - Interrupt pin gated by enable; summary unaffected
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`include "ccr_consts.vh"
module ccr_codec_ctrl #(
  parameter SAMPLE_DIV = `CCR_SAMPLE_DIV
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        play_byte_valid,
  input  wire [7:0]  play_byte,
  input  wire        cap_sample_done,
  output reg  [15:0] dac_left,
  output reg  [15:0] dac_right,
  output reg         dac_valid,
  output reg         play_dma_run,
  output reg         cap_dma_run,
  output reg         play_fifo_flush,
  output reg         cap_fifo_flush,
  output reg  [7:0]  play_rate_sel,
  output reg  [7:0]  cap_rate_sel,
  output reg  [3:0]  play_format,
  output reg  [3:0]  cap_format,
  output reg         dac_mute,
  output reg         mixer_mute,
  output reg         mixer_cal,
  output reg         adc_cal,
  output reg         dac_cal,
  output reg         dac_filter_clear,
  output reg         sample_tick,
  output reg         irq
);
  localparam CAL_IDLE = 2'b01;
  localparam CAL_RUN  = 2'b10;

  // 8-bit offset binary to 16-bit two's complement
  function [15:0] ext8;
    input [7:0] b;
    begin
      ext8 = {b ^ 8'h80, 8'h00};
    end
  endfunction

  reg         mce_r;
  reg  [10:0] cfg_r;
  reg  [7:0]  ratefmt_r;
  reg  [7:0]  capfmt_r;
  reg  [7:0]  altrate_r;
  reg         independent_rate_enable_r;
  reg  [7:0]  caprate_r;
  reg  [7:0]  playrate_r;
  reg  [1:0]  afc_r;
  reg  [15:0] pbase_r;
  reg  [15:0] cbase_r;
  reg  [15:0] pcount_r;
  reg  [15:0] ccount_r;
  reg         pflag_r;
  reg         cflag_r;
  reg  [11:0] div_r;
  reg  [1:0]  cal_st_r;
  reg  [8:0]  cal_cnt_r;
  reg  [1:0]  cal_mode_r;
  reg  [1:0]  busy_cnt_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg  [1:0]  byte_idx_r;
  reg  [15:0] left_r;
  reg  [15:0] right_r;

  wire        ext      = cfg_r[`CCR_CFG_EXT];
  wire        busy     = (busy_cnt_r != 2'd0);
  wire        wr_go    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        wr_ok    = wr_go && !busy;
  wire        l0       = wstrb_r[0];
  wire        l1       = wstrb_r[1];
  wire        w_index  = wr_ok && awaddr_r == `CCR_OFF_INDEX && l0;
  wire        w_status = wr_ok && awaddr_r == `CCR_OFF_STATUS;
  wire        w_cfg    = wr_ok && awaddr_r == `CCR_OFF_CONFIG;
  wire        w_rate   = wr_ok && awaddr_r == `CCR_OFF_RATEFMT && l0;
  wire        w_capfmt = wr_ok && awaddr_r == `CCR_OFF_CAPFMT && l0;
  wire        w_afstat = wr_ok && awaddr_r == `CCR_OFF_AFSTAT && l0;
  wire        w_pbase  = wr_ok && awaddr_r == `CCR_OFF_PBASE;
  wire        w_cbase  = wr_ok && awaddr_r == `CCR_OFF_CBASE && ext;
  wire        alt_rate_enable      = altrate_r[`CCR_ALT_SRE];
  wire        cal_busy = (cal_st_r == CAL_RUN);
  wire        mce_fall = w_index && mce_r && !wdata_r[`CCR_IDX_MCE];
  wire        pdn_fall = w_cfg && l1 && cfg_r[`CCR_CFG_PDN]
                         && !wdata_r[`CCR_CFG_PDN];
  wire        pfc_rise = wr_ok && awaddr_r == `CCR_OFF_AFCTRL && l0
                         && ext && wdata_r[`CCR_AFC_PLAY_FORMAT_CHANGE] && !afc_r[0];
  wire        cfc_rise = wr_ok && awaddr_r == `CCR_OFF_AFCTRL && l0
                         && ext && wdata_r[`CCR_AFC_CAP_FORMAT_CHANGE] && !afc_r[1];
  // Basic mode needs mode-change; extended also per-direction enable
  wire        pfmt_ok  = mce_r || (ext && afc_r[0]);
  wire        cfmt_ok  = mce_r || (ext && afc_r[1]);
  wire        p_wide   = ratefmt_r[`CCR_FMT_WIDE];
  wire        p_stereo = ratefmt_r[`CCR_FMT_STEREO];
  wire [1:0]  last_idx = {p_stereo, p_wide};
  wire        p_sample = play_dma_run && play_byte_valid
                         && byte_idx_r == (p_stereo ? (p_wide ? 2'd3 : 2'd1)
                                                    : (p_wide ? 2'd1 : 2'd0));
  wire        c_sample = cap_dma_run && cap_sample_done;
  // Basic mode: capture shares the playback counter
  wire        p_evt    = p_sample || (!ext && c_sample);
  wire        c_evt    = ext && c_sample;
  wire        p_roll   = p_evt && pcount_r == 16'h0000;
  wire        c_roll   = c_evt && ccount_r == 16'h0000;
  wire        clr_p    = w_status || (w_afstat && !wdata_r[`CCR_AFS_PI]);
  wire        clr_c    = w_status || (w_afstat && !wdata_r[`CCR_AFS_CI]);

  // AXI write channel: address and data taken in any order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCR_RESP_OKAY;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r > `CCR_OFF_CCOUNT || awaddr_r[1:0] != 2'b00)
                        ? `CCR_RESP_SLVERR : `CCR_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read channel
  reg [31:0] rd_mux;
  reg        rd_err;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `CCR_OFF_INDEX:    rd_mux = {31'h0000_0000, mce_r};
      `CCR_OFF_STATUS:   rd_mux = {31'h0000_0000, pflag_r | cflag_r};
      `CCR_OFF_CONFIG:   rd_mux = {21'h00_0000, cfg_r};
      `CCR_OFF_RATEFMT:  rd_mux = {24'h00_0000, ratefmt_r};
      `CCR_OFF_CAPFMT:   rd_mux = {24'h00_0000, capfmt_r};
      `CCR_OFF_ALTRATE:  rd_mux = {24'h00_0000, altrate_r};
      `CCR_OFF_INDCTRL:  rd_mux = {31'h0000_0000, independent_rate_enable_r};
      `CCR_OFF_CAPRATE:  rd_mux = {24'h00_0000, caprate_r};
      `CCR_OFF_PLAYRATE: rd_mux = {24'h00_0000, playrate_r};
      `CCR_OFF_AFCTRL:   rd_mux = {30'h0000_0000, afc_r};
      `CCR_OFF_AFSTAT:   rd_mux = {26'h000_0000, cflag_r, pflag_r,
                                   3'b000, cal_busy};
      `CCR_OFF_PBASE:    rd_mux = {16'h0000, pbase_r};
      `CCR_OFF_CBASE:    rd_mux = {16'h0000, cbase_r};
      `CCR_OFF_PCOUNT:   rd_mux = {16'h0000, pcount_r};
      `CCR_OFF_CCOUNT:   rd_mux = {16'h0000, ccount_r};
      default:           rd_err = 1'b1;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCR_RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= busy ? `CCR_BUSY_VALUE : rd_mux;
      s_axi_rresp   <= (rd_err && !busy) ? `CCR_RESP_SLVERR : `CCR_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mce_r      <= 1'b0;
      cfg_r      <= 11'h000;
      ratefmt_r  <= `CCR_RST_BYTE;
      capfmt_r   <= `CCR_RST_BYTE;
      altrate_r  <= `CCR_RST_BYTE;
      independent_rate_enable_r     <= 1'b0;
      caprate_r  <= `CCR_RST_BYTE;
      playrate_r <= `CCR_RST_BYTE;
      afc_r      <= 2'b00;
      pbase_r    <= `CCR_RST_BASE;
      cbase_r    <= `CCR_RST_BASE;
    end
    else
    begin
      if (w_index)
        mce_r <= wdata_r[`CCR_IDX_MCE];
      if (w_cfg && l0)
      begin
        cfg_r[`CCR_CFG_PEN] <= wdata_r[`CCR_CFG_PEN];
        cfg_r[`CCR_CFG_CEN] <= wdata_r[`CCR_CFG_CEN];
        cfg_r[`CCR_CFG_IEN] <= wdata_r[`CCR_CFG_IEN];
        if (mce_r)
        begin
          cfg_r[1:0]           <= wdata_r[1:0];
          cfg_r[`CCR_CFG_PLAY_PROG_IO] <= wdata_r[`CCR_CFG_PLAY_PROG_IO];
          cfg_r[`CCR_CFG_CAP_PROG_IO] <= wdata_r[`CCR_CFG_CAP_PROG_IO];
          cfg_r[`CCR_CFG_EXT]  <= wdata_r[`CCR_CFG_EXT];
        end
      end
      if (w_cfg && l1)
        cfg_r[10:8] <= wdata_r[10:8];
      if (w_rate)
      begin
        if (mce_r)
          ratefmt_r[3:0] <= wdata_r[3:0];
        if (pfmt_ok)
          ratefmt_r[7:4] <= wdata_r[7:4];
      end
      if (w_capfmt && ext && cfmt_ok)
        capfmt_r[7:4] <= wdata_r[7:4];
      if (wr_ok && awaddr_r == `CCR_OFF_ALTRATE && l0)
        altrate_r <= wdata_r[7:0];
      if (wr_ok && awaddr_r == `CCR_OFF_INDCTRL && l0)
        independent_rate_enable_r <= wdata_r[`CCR_IND_INDEPENDENT_RATE_ENABLE];
      if (wr_ok && awaddr_r == `CCR_OFF_CAPRATE && l0)
        caprate_r <= wdata_r[7:0];
      if (wr_ok && awaddr_r == `CCR_OFF_PLAYRATE && l0)
        playrate_r <= wdata_r[7:0];
      if (wr_ok && awaddr_r == `CCR_OFF_AFCTRL && l0)
        afc_r <= ext ? wdata_r[1:0] : 2'b00;
      if (w_pbase && l0)
        pbase_r[7:0] <= wdata_r[7:0];
      if (w_pbase && l1)
        pbase_r[15:8] <= wdata_r[15:8];
      if (w_cbase && l0)
        cbase_r[7:0] <= wdata_r[7:0];
      if (w_cbase && l1)
        cbase_r[15:8] <= wdata_r[15:8];
    end
  end

  // Sample strobe and resynchronisation after a clock change
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_r       <= 12'h000;
      sample_tick <= 1'b0;
      busy_cnt_r  <= 2'd0;
    end
    else
    begin
      sample_tick <= (div_r == 12'h000);
      div_r <= (div_r == 12'h000) ? SAMPLE_DIV[11:0] - 12'h001
                                  : div_r - 12'h001;
      if (w_rate && mce_r && wdata_r[3:0] != ratefmt_r[3:0]
          && !alt_rate_enable && !independent_rate_enable_r)
        busy_cnt_r <= `CCR_RESYNC_PER;
      else if (busy && sample_tick)
        busy_cnt_r <= busy_cnt_r - 2'd1;
    end
  end

  // Calibration sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Power-up calibration pending from reset on: no unmuted gap
      cal_st_r   <= CAL_RUN;
      cal_cnt_r  <= `CCR_CAL_FULL_PER;
      cal_mode_r <= 2'b11;
    end
    else
    begin
      case (cal_st_r)
        CAL_IDLE:
          if (pdn_fall)
          begin
            cal_mode_r <= 2'b11;
            cal_cnt_r  <= `CCR_CAL_FULL_PER;
            cal_st_r   <= CAL_RUN;
          end
          else if (mce_fall && cfg_r[1:0] != 2'b00)
          begin
            cal_mode_r <= cfg_r[1:0];
            cal_cnt_r  <= (cfg_r[1:0] == 2'b11) ? `CCR_CAL_FULL_PER :
                          (cfg_r[1:0] == 2'b10) ? `CCR_CAL_DAC_PER :
                                                  `CCR_CAL_CONV_PER;
            cal_st_r   <= CAL_RUN;
          end
        CAL_RUN:
          if (sample_tick)
          begin
            cal_cnt_r <= cal_cnt_r - 9'd1;
            if (cal_cnt_r == 9'd1)
              cal_st_r <= CAL_IDLE;
          end
        default:
          cal_st_r <= CAL_IDLE;
      endcase
    end
  end

  // Registered calibration phase outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dac_mute         <= 1'b1;
      mixer_mute       <= 1'b1;
      mixer_cal        <= 1'b0;
      adc_cal          <= 1'b0;
      dac_cal          <= 1'b0;
      dac_filter_clear <= 1'b0;
    end
    else
    begin
      dac_mute   <= cal_busy;
      mixer_mute <= cal_busy && cal_mode_r == 2'b11;
      mixer_cal  <= cal_busy && cal_mode_r == 2'b11
                    && cal_cnt_r > `CCR_FULL_ADC_AT;
      adc_cal    <= cal_busy && ((cal_mode_r == 2'b11
                    && cal_cnt_r <= `CCR_FULL_ADC_AT
                    && cal_cnt_r > `CCR_FULL_DAC_AT)
                    || (cal_mode_r == 2'b01
                    && cal_cnt_r > `CCR_CONV_DAC_AT));
      dac_cal    <= cal_busy && ((cal_mode_r == 2'b11
                    && cal_cnt_r <= `CCR_FULL_DAC_AT)
                    || (cal_mode_r == 2'b01
                    && cal_cnt_r <= `CCR_CONV_DAC_AT));
      dac_filter_clear <= cal_busy && cal_mode_r == 2'b10;
    end
  end

  // Rate, format and DMA enables
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      play_rate_sel   <= 8'h00;
      cap_rate_sel    <= 8'h00;
      play_format     <= 4'h0;
      cap_format      <= 4'h0;
      play_dma_run    <= 1'b0;
      cap_dma_run     <= 1'b0;
      play_fifo_flush <= 1'b0;
      cap_fifo_flush  <= 1'b0;
      irq             <= 1'b0;
    end
    else
    begin
      if (independent_rate_enable_r)
      begin
        play_rate_sel <= playrate_r;
        cap_rate_sel  <= caprate_r;
      end
      else if (alt_rate_enable)
      begin
        play_rate_sel <= {cfg_r[`CCR_CFG_OSM_HI], cfg_r[`CCR_CFG_OSM_LO],
                          altrate_r[6:1]};
        cap_rate_sel  <= {cfg_r[`CCR_CFG_OSM_HI], cfg_r[`CCR_CFG_OSM_LO],
                          altrate_r[6:1]};
      end
      else
      begin
        play_rate_sel <= {4'h0, ratefmt_r[3:0]};
        cap_rate_sel  <= {4'h0, ratefmt_r[3:0]};
      end
      play_format <= ratefmt_r[7:4];
      cap_format  <= ext ? capfmt_r[7:4] : ratefmt_r[7:4];
      play_dma_run <= cfg_r[`CCR_CFG_PEN] && !cfg_r[`CCR_CFG_PLAY_PROG_IO]
                      && !cal_busy;
      cap_dma_run  <= cfg_r[`CCR_CFG_CEN] && !cfg_r[`CCR_CFG_CAP_PROG_IO]
                      && !cal_busy && (ext || !(cfg_r[`CCR_CFG_PEN]
                      && !cfg_r[`CCR_CFG_PLAY_PROG_IO]));
      play_fifo_flush <= pfc_rise;
      cap_fifo_flush  <= cfc_rise;
      irq <= (pflag_r || cflag_r) && cfg_r[`CCR_CFG_IEN];
    end
  end

  // Current counters and interrupt flags; a set beats a clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pcount_r <= `CCR_RST_BASE;
      ccount_r <= `CCR_RST_BASE;
      pflag_r  <= 1'b0;
      cflag_r  <= 1'b0;
    end
    else
    begin
      if (w_pbase && l1)
        pcount_r <= {wdata_r[15:8], l0 ? wdata_r[7:0] : pbase_r[7:0]};
      else if (p_roll)
        pcount_r <= pbase_r;
      else if (p_evt)
        pcount_r <= pcount_r - 16'h0001;
      if (w_cbase && l1)
        ccount_r <= {wdata_r[15:8], l0 ? wdata_r[7:0] : cbase_r[7:0]};
      else if (c_roll)
        ccount_r <= cbase_r;
      else if (c_evt)
        ccount_r <= ccount_r - 16'h0001;
      pflag_r <= p_roll || (pflag_r && !clr_p);
      cflag_r <= c_roll || (cflag_r && !clr_c);
    end
  end

  // Playback byte stream to samples: left first, low byte first
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      byte_idx_r <= 2'd0;
      left_r     <= 16'h0000;
      right_r    <= 16'h0000;
      dac_left   <= 16'h0000;
      dac_right  <= 16'h0000;
      dac_valid  <= 1'b0;
    end
    else
    begin
      dac_valid <= 1'b0;
      if (pfc_rise || !play_dma_run)
        byte_idx_r <= 2'd0;
      else if (play_byte_valid)
      begin
        byte_idx_r <= p_sample ? 2'd0 : byte_idx_r + 2'd1;
        if (p_wide)
        begin
          case (byte_idx_r)
            2'd0: left_r[7:0]   <= play_byte;
            2'd1: left_r[15:8]  <= play_byte;
            2'd2: right_r[7:0]  <= play_byte;
            default: right_r[15:8] <= play_byte;
          endcase
        end
        else if (byte_idx_r == 2'd0)
          left_r <= ext8(play_byte);
        else
          right_r <= ext8(play_byte);
        if (p_sample)
        begin
          dac_valid <= 1'b1;
          dac_left  <= (!p_wide && last_idx == 2'd0) ? ext8(play_byte)
                       : (p_wide && !p_stereo) ? {play_byte, left_r[7:0]}
                       : left_r;
          dac_right <= !p_stereo
                       ? (p_wide ? {play_byte, left_r[7:0]} : ext8(play_byte))
                       : (p_wide ? {play_byte, right_r[7:0]}
                                 : ext8(play_byte));
        end
      end
    end
  end

endmodule // ccr_codec_ctrl

// file: tb/ccr_dma_host.sv
// Host DMA controller model: playback bytes and capture samples
// Assumes bench requests, honoured only while the block allows DMA
module ccr_dma_host (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        play_dma_run,
  input  wire        cap_dma_run,
  input  wire        req_play,
  input  wire        req_cap,
  input  wire [7:0]  req_byte,
  output logic       play_byte_valid,
  output logic [7:0] play_byte,
  output logic       cap_sample_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial play_byte = 8'h5a;
  always @(posedge aclk)
  begin
    play_byte_valid <= aresetn && req_play && play_dma_run;
    cap_sample_done <= aresetn && req_cap && cap_dma_run;
    // Released bus shows changing junk between bytes
    play_byte <= req_play ? req_byte : ~play_byte;
  end
endmodule // ccr_dma_host

// file: tb/ccr_codec_ctrl_properties.sv
// Checker for calibration phases, strobes and flush pulses
// Assumes binding to ccr_codec_ctrl, single clock domain
module ccr_codec_ctrl_checker (
  input wire aclk,
  input wire aresetn,
  input wire sample_tick,
  input wire play_fifo_flush,
  input wire cap_fifo_flush,
  input wire dac_mute,
  input wire mixer_mute,
  input wire mixer_cal,
  input wire adc_cal,
  input wire dac_cal,
  input wire dac_filter_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence mix_end_s;
    $fell(mixer_cal);
  endsequence
  sequence adc_end_s;
    $fell(adc_cal);
  endsequence
  tick_pulse_a: assert property (sample_tick |=> !sample_tick)
    else $error("sample strobe longer than one cycle");
  play_flush_a: assert property (play_fifo_flush |=> !play_fifo_flush)
    else $error("playback flush longer than one cycle");
  cap_flush_a: assert property (cap_fifo_flush |=> !cap_fifo_flush)
    else $error("capture flush longer than one cycle");
  mix_mute_a: assert property (mixer_mute |-> dac_mute)
    else $error("mixer muted without dac mute");
  mixcal_mute_a: assert property (mixer_cal |-> mixer_mute && dac_mute)
    else $error("mixer calibrating while unmuted");
  conv_mute_a: assert property (adc_cal || dac_cal |-> dac_mute)
    else $error("converter calibration while dacs unmuted");
  filt_clear_a: assert property (dac_filter_clear |-> dac_mute && !adc_cal)
    else $error("filter clear without mute or with adc busy");
  phase_one_a: assert property ($onehot0({mixer_cal, adc_cal, dac_cal}))
    else $error("two calibration phases at once");
  mix_adc_a: assert property (mix_end_s |-> ##[0:1] adc_cal)
    else $error("adc phase does not follow mixer phase");
  adc_dac_a: assert property (adc_end_s |-> ##[0:1] dac_cal)
    else $error("dac phase does not follow adc phase");
endmodule // ccr_codec_ctrl_checker
bind ccr_codec_ctrl ccr_codec_ctrl_checker ccr_chk_inst (.aclk(aclk),
  .aresetn(aresetn), .sample_tick(sample_tick), .dac_mute(dac_mute),
  .play_fifo_flush(play_fifo_flush), .cap_fifo_flush(cap_fifo_flush),
  .mixer_mute(mixer_mute), .mixer_cal(mixer_cal), .adc_cal(adc_cal),
  .dac_cal(dac_cal), .dac_filter_clear(dac_filter_clear));

// file: tb/testbench.sv
// Self-checking bench for the codec control block over AXI4-Lite
// Assumes the DMA host model and bound checker compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, rqp = 0, rqc = 0;
  logic [7:0] awa = 0, ara = 0, rqb = 0, r4, r6, b;
  logic [31:0] wd = 0, rd_val, m, v;
  logic [1:0] rd_rsp, wr_rsp;
  wire awr, wr_r, bv, arr, rv, pbv, csd, dv, prun, crun, pfl, cfl;
  wire dmute, tick, irq;
  wire [1:0] brsp, rrsp;
  wire [31:0] rdat;
  wire [15:0] dl, dr;
  wire [7:0] pb, prs, crs;
  wire [3:0] pfm, cfm;
  int n_errors = 0, n_checks = 0, nfp = 0, nfc = 0;
  int cl[4] = '{0, 321, 120, 450};
  logic [7:0] bl[3] = '{8'h00, 8'h80, 8'hff};
  logic [31:0] qe[$], qm[$], qd[$];
  always #4 aclk = ~aclk;
  ccr_codec_ctrl #(.SAMPLE_DIV(8)) ccr_codec_ctrl_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(brsp),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .play_byte_valid(pbv), .play_byte(pb), .cap_sample_done(csd),
    .dac_left(dl), .dac_right(dr), .dac_valid(dv), .play_dma_run(prun),
    .cap_dma_run(crun), .play_fifo_flush(pfl), .cap_fifo_flush(cfl),
    .play_rate_sel(prs), .cap_rate_sel(crs), .play_format(pfm),
    .cap_format(cfm), .dac_mute(dmute), .mixer_mute(), .mixer_cal(),
    .adc_cal(), .dac_cal(), .dac_filter_clear(), .sample_tick(tick),
    .irq(irq));
  ccr_dma_host ccr_dma_host_inst (.aclk(aclk), .aresetn(aresetn),
    .play_dma_run(prun), .cap_dma_run(crun), .req_play(rqp),
    .req_cap(rqc), .req_byte(rqb), .play_byte_valid(pbv),
    .play_byte(pb), .cap_sample_done(csd));
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic tmo();
    n_errors++;
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv) break;
    end
    wr_rsp = brsp;
    if (n == 200) tmo();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, mk);
    int n;
    qe.push_back(e);
    qm.push_back(mk);
    ara <= a;
    arv <= 1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rd_val = rdat;
    rd_rsp = rrsp;
    if (n == 200) tmo();
  endtask
  task automatic sb(input logic [7:0] x, input logic c);
    rqb <= x;
    rqp <= !c;
    rqc <= c;
    @(posedge aclk);
    rqp <= 0;
    rqc <= 0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic cal(input int e);
    int n = 0, t = 0;
    for (int i = 0; i < 20 && !dmute; i++) @(posedge aclk);
    while (dmute && t < 5000)
    begin
      @(posedge aclk);
      t++;
      n += tick;
    end
    if (t == 5000) tmo();
    chk(n + 2 >= e && n <= e + 1, 1);
    rd(8'h28, 0, 1);
  endtask
  always @(posedge aclk)
  begin
    if (rv)
    begin
      m = qm.pop_front();
      chk(rdat & m, qe.pop_front() & m);
    end
    if (dv) chk({dl, dr}, qd.pop_front());
    nfp += pfl;
    nfc += cfl;
  end
  initial
  begin
    void'($urandom(4));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(8'h28, 1, 1);
    cal(450);
    foreach (cl[i])
    begin
      wr(0, 1);
      wr(8, i);
      wr(0, 0);
      cal(cl[i]);
    end
    r4 = 8'($urandom_range(15, 1));
    wr(0, 1);
    wr(8, 8'h80);
    wr(8'h2c, 5);
    wr(8'h0c, r4);
    rd(0, 32'h0000_0080, '1);
    wr(8'h2c, 8'h77);
    for (int i = 0; i < 50 && rd_val == 8'h80; i++) rd(0, 0, 0);
    rd(8'h34, 5, 16'hffff);
    wr(0, 0);
    r6 = 8'($urandom_range(63));
    wr(8'h14, {r6, 1'b1});
    repeat (2) @(posedge aclk);
    chk(prs, r6);
    b = 8'($urandom);
    wr(8'h18, 1);
    wr(8'h1c, b);
    wr(8'h20, ~b);
    repeat (2) @(posedge aclk);
    chk({crs, prs}, {b, ~b});
    wr(8'h24, 3);
    wr(8'h0c, 8'h30);
    wr(8'h10, 8'h20);
    rd(8'h0c, {4'h3, r4[3:0]}, 8'hff);
    wr(8'h24, 0);
    chk({nfp[7:0], nfc[7:0], pfm, cfm}, {8'h01, 8'h01, 8'h32});
    wr(0, 1);
    wr(8, 8'hb0);
    wr(0, 0);
    wr(8'h2c, 2);
    wr(8'h30, 0);
    chk({prun, crun}, 2'b11);
    for (int k = 0; k < 3; k++)
    begin
      v = $urandom;
      qd.push_back(v);
      sb(v[23:16], 0);
      sb(v[31:24], 0);
      sb(v[7:0], 0);
      sb(v[15:8], 0);
    end
    rd(8'h34, 2, 16'hffff);
    rd(8'h28, 8'h10, 8'h31);
    rd(4, 1, 1);
    chk(irq, 0);
    wr(8, 8'hf0);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    wr(4, 0);
    rd(4, 0, 1);
    wr(8'h24, 1);
    wr(8'h0c, 0);
    wr(8'h24, 0);
    foreach (bl[i])
    begin
      qd.push_back({bl[i] ^ 8'h80, 8'h00, bl[i] ^ 8'h80, 8'h00});
      sb(bl[i], 0);
    end
    sb(0, 1);
    rd(8'h28, 8'h20, 8'h20);
    wr(8'h28, 0);
    rd(8'h28, 0, 8'h30);
    rd(8'h3c, 0, '1);
    chk(rd_rsp, 2);
    wr(8'h3c, 0);
    chk(wr_rsp, 2);
    wr(8, 32'h0000_0100);
    wr(8, 0);
    cal(450);
    final_report();
  end
endmodule // testbench
